// *** rtl/csrc_pkg.sv ***
// Constants for the comparator sleep and reset control block.
// Assumes a 32-bit classic Wishbone slave with word addressing by byte.
package csrc_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_FLAG   = 8'h04;
    localparam logic [7:0] OFS_IRQEN  = 8'h08;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int CIS_BIT  = 3;
    localparam int INV1_BIT = 4;
    localparam int INV2_BIT = 5;
    localparam int OUT1_BIT = 6;
    localparam int OUT2_BIT = 7;

    // ----------------------------------------
    // Flag and enable register fields
    // ----------------------------------------
    localparam int FLAG_BIT = 0;
    localparam int COMPARATOR_IRQ_ENABLE_BIT = 0;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 1;
    localparam int GIE_BIT  = 2;

    // ----------------------------------------
    // Mode codes and reset values
    // ----------------------------------------
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] MODE_OFF   = 3'h7;
    localparam logic [5:0] CTRL_RST   = 6'h00;
    localparam logic [2:0] IRQEN_RST  = 3'h0;
    localparam logic [3:0] ANALOG_ALL = 4'hF;
    localparam logic [3:0] ANALOG_NONE = 4'h0;
    localparam int SYNC_STAGES = 2;
endpackage : csrc_pkg

// *** rtl/csrc_sync.sv ***
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the inputs are quasi-static compared with clk_i.
`timescale 1ns/1ns
`default_nettype none
module csrc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : csrc_sync
`default_nettype wire

// *** rtl/csrc_top.sv ***
// What this block does
// - In sleep an active comparator and its interrupt logic keep running.
// - An enabled comparator interrupt during sleep wakes the device.
// - Waking from sleep leaves every control register bit unchanged.
// - Any reset returns the control register to reset value, mode 000.
// - Reset mode makes every comparator-capable pin an analog input.
// - Both comparators stay powered down while reset is asserted.
// - Change flag sets on any comparator output change, enabled or not.
// - Interrupt goes out only when local, peripheral and global enables set.
//
// Comparator control: Wishbone slave, pin synchronisers, change flag,
// interrupt and sleep wake. Assumes sleep_i comes from logic on clk_i.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module csrc_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Analog comparator side
    input  wire logic [1:0]  cmp_raw_i,
    output logic      [1:0]  cmp_power_o,
    output logic      [3:0]  pin_analog_o,
    output logic             input_switch_o,
    // Power management
    input  wire logic        sleep_i,
    output logic             wake_o,
    output logic             irq_o
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic        req;
    logic        wr_ctrl;
    logic        wr_flag;
    logic        wr_irqen;
    logic        hit;
    logic [31:0] rd_d;

    assign req      = cyc_i && stb_i && !ack_o;
    assign wr_ctrl  = req && we_i && sel_i[0] && (adr_i == csrc_pkg::OFS_CTRL);
    assign wr_flag  = req && we_i && sel_i[0] && (adr_i == csrc_pkg::OFS_FLAG);
    assign wr_irqen = req && we_i && sel_i[0] && (adr_i == csrc_pkg::OFS_IRQEN);
    assign hit      = (adr_i == csrc_pkg::OFS_CTRL) || (adr_i == csrc_pkg::OFS_FLAG)
                      || (adr_i == csrc_pkg::OFS_IRQEN);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [5:0] ctrl_q;
    logic [2:0] irqen_q;
    logic       flag_q;
    logic [1:0] cmp_out_q;
    logic [1:0] cmp_sync;
    logic [2:0] mode;
    logic       cmp_on;
    logic [1:0] cmp_out_d;
    logic       change;

    assign mode   = ctrl_q[csrc_pkg::MODE_MSB:csrc_pkg::MODE_LSB];
    // Power follows the mode only; sleep has no say in it
    assign cmp_on = (mode != csrc_pkg::MODE_RESET) && (mode != csrc_pkg::MODE_OFF);

    // Sleep is not an input here, so wake cannot disturb the field
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= csrc_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= dat_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irqen_q <= csrc_pkg::IRQEN_RST;
        end else if (wr_irqen) begin
            irqen_q <= dat_i[2:0];
        end
    end

    // ----------------------------------------
    // Comparator outputs
    // ----------------------------------------
    csrc_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (cmp_raw_i),
        .q_o   (cmp_sync)
    );

    // Unpowered comparators read as zero so a power-down is a visible change
    assign cmp_out_d = cmp_on ? (cmp_sync ^ {ctrl_q[csrc_pkg::INV2_BIT],
                                             ctrl_q[csrc_pkg::INV1_BIT]}) : 2'h0;
    assign change    = (cmp_out_d != cmp_out_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_out_q <= 2'h0;
        end else begin
            cmp_out_q <= cmp_out_d;
        end
    end

    // ----------------------------------------
    // Change flag
    // ----------------------------------------
    // Set wins over a software clear in the same cycle; writing 1 fakes an event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (change) begin
            flag_q <= 1'b1;
        end else if (wr_flag) begin
            flag_q <= dat_i[csrc_pkg::FLAG_BIT];
        end
    end

    // ----------------------------------------
    // Pin, power, interrupt and wake outputs
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_power_o    <= 2'h0;
            pin_analog_o   <= csrc_pkg::ANALOG_ALL;
            input_switch_o <= 1'b0;
        end else begin
            cmp_power_o    <= {cmp_on, cmp_on};
            pin_analog_o   <= (mode == csrc_pkg::MODE_OFF) ? csrc_pkg::ANALOG_NONE
                                                           : csrc_pkg::ANALOG_ALL;
            input_switch_o <= ctrl_q[csrc_pkg::CIS_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= flag_q && irqen_q[csrc_pkg::COMPARATOR_IRQ_ENABLE_BIT] && irqen_q[csrc_pkg::PERIPHERAL_IRQ_ENABLE_BIT]
                     && irqen_q[csrc_pkg::GIE_BIT];
        end
    end

    // Wake needs only the local enable, as the core may sleep with interrupts off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= sleep_i && flag_q && irqen_q[csrc_pkg::COMPARATOR_IRQ_ENABLE_BIT];
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (adr_i)
            csrc_pkg::OFS_CTRL: rd_d = {24'h00_0000, cmp_out_q, ctrl_q};
            csrc_pkg::OFS_FLAG: rd_d = {31'h0000_0000, flag_q};
            csrc_pkg::OFS_IRQEN: rd_d = {29'h0000_0000, irqen_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Unmapped addresses still ack, reading zero, so the bus never hangs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= (req && !we_i && hit) ? rd_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_sleep_keeps_power: assert property (@(posedge clk_i) disable iff (rst_i)
        (sleep_i && cmp_on) |=> cmp_power_o == 2'h3)
        else $error("comparator powered off during sleep");

    a_wake_on_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        (sleep_i && flag_q && irqen_q[csrc_pkg::COMPARATOR_IRQ_ENABLE_BIT]) |=> wake_o)
        else $error("enabled comparator event did not wake");

    a_wake_needs_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_o |-> $past(sleep_i) && $past(flag_q))
        else $error("wake without sleep and flag");

    a_sleep_ctrl_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(wr_ctrl) && $rose(sleep_i) || $fell(sleep_i) && !$past(wr_ctrl))
        |-> $stable(ctrl_q))
        else $error("control changed across sleep edge");

    a_reset_mode_zero: assert property (@(posedge clk_i)
        $past(rst_i) |-> (mode == csrc_pkg::MODE_RESET) && (irqen_q == 3'h0))
        else $error("reset did not clear control");

    a_reset_mode_analog: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(mode) == csrc_pkg::MODE_RESET) |-> pin_analog_o == 4'hF)
        else $error("reset mode pins not analog");

    a_reset_power_down: assert property (@(posedge clk_i)
        $past(rst_i) |-> cmp_power_o == 2'h0 ##1 (cmp_power_o == 2'h0))
        else $error("comparator powered during reset");

    a_change_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmp_out_d != cmp_out_q) |=> flag_q ##1 (cmp_out_q == $past(cmp_out_d, 2)))
        else $error("output change missed");

    a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> $past(flag_q) && ($past(irqen_q) == 3'h7))
        else $error("interrupt without all enables");

    a_off_mode_power: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(mode) == csrc_pkg::MODE_OFF) |-> cmp_power_o == 2'h0
        && pin_analog_o == 4'h0)
        else $error("off mode left comparators on");

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held two cycles");
endmodule : csrc_top
`default_nettype wire

// *** tb/csrc_top_tb.sv ***
// Self-checking bench for the comparator sleep and reset control block.
// Assumes csrc_top and csrc_pkg are compiled first; bench drives all ports.
`timescale 1ns/1ns
`default_nettype none
module csrc_top_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [1:0]  raw;
    logic [1:0]  cmp_power_o;
    logic [3:0]  pin_analog_o;
    logic        input_switch_o;
    logic        sleep;
    logic        wake_o;
    logic        irq_o;
    logic [31:0] rd;
    int          err_count;
    int          checked;

    csrc_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .cmp_raw_i(raw), .cmp_power_o(cmp_power_o), .pin_analog_o(pin_analog_o),
        .input_switch_o(input_switch_o), .sleep_i(sleep), .wake_o(wake_o),
        .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Ack and data are read at the rising edge, before that edge's own updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0000_0001, 32'h0000_0000);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    // Ends on a rising edge so the next drive lands there by non-blocking assignment
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : settle

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        err_count = 0;
        checked = 0;
        rst_i = 1'b1;
        {cyc, stb, we, adr, wdat, raw, sleep} = '0;
        sel = 4'h1;
        settle(4);
        chk(cmp_power_o, 2'h0);
        rst_i <= 1'b0;
        wb(1'b0, csrc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(pin_analog_o, 4'hF);
        chk(input_switch_o, 1'b0);
        wb(1'b0, csrc_pkg::OFS_IRQEN, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wb(1'b0, 8'hFC, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("reset values test done");

        for (int m = 1; m < 8; m++) begin
            wb(1'b1, csrc_pkg::OFS_CTRL, 32'(m) | 32'h0000_0008);
            settle(3);
            chk(cmp_power_o, (m == 7) ? 2'h0 : 2'h3);
            chk(pin_analog_o, (m == 7) ? 4'h0 : 4'hF);
            chk(input_switch_o, 1'b1);
        end
        $display("mode codes test done");

        wb(1'b1, csrc_pkg::OFS_CTRL, 32'h0000_0001);
        settle(8);
        wb(1'b1, csrc_pkg::OFS_FLAG, 32'h0000_0000);
        raw <= 2'h1;
        settle(8);
        wb(1'b0, csrc_pkg::OFS_FLAG, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        chk(irq_o, 1'b0);
        wb(1'b1, csrc_pkg::OFS_IRQEN, 32'h0000_0003);
        wb(1'b1, csrc_pkg::OFS_FLAG, 32'h0000_0000);
        raw <= 2'h0;
        settle(8);
        chk(irq_o, 1'b0);
        wb(1'b1, csrc_pkg::OFS_IRQEN, 32'h0000_0007);
        settle(2);
        chk(irq_o, 1'b1);
        $display("change flag test done");

        // Only the local enable is needed for wake, per the design's choice
        wb(1'b1, csrc_pkg::OFS_IRQEN, 32'h0000_0001);
        wb(1'b1, csrc_pkg::OFS_CTRL, 32'h0000_0031);
        settle(8);
        wb(1'b1, csrc_pkg::OFS_FLAG, 32'h0000_0000);
        sleep <= 1'b1;
        settle(3);
        chk(wake_o, 1'b0);
        chk(cmp_power_o, 2'h3);
        raw <= 2'h2;
        settle(8);
        chk(wake_o, 1'b1);
        wb(1'b0, csrc_pkg::OFS_FLAG, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        sleep <= 1'b0;
        wb(1'b0, csrc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd & 32'h0000_003F, 32'h0000_0031);
        $display("sleep wake test done");

        @(posedge clk_i);
        rst_i <= 1'b1;
        settle(4);
        chk(cmp_power_o, 2'h0);
        chk(pin_analog_o, 4'hF);
        rst_i <= 1'b0;
        wb(1'b0, csrc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd & 32'h0000_003F, 32'h0000_0000);
        $display("mid-run reset test done");
        print_verdict();
    end

    // A hang outside the 20-cycle bounded bus wait ends the run at 10000 cycles, well past the roughly 140 cycles needed
    initial begin
        #100000;
        err_count++;
        print_verdict();
    end
endmodule : csrc_top_tb
`default_nettype wire
